/* File: hw/sep_eeprom_slave.sv */
// Purpose: two-wire slave front end and sequencer for a 4K x 8 memory
// Assumes: master drives the serial clock; open-drain data wire
// Notes: memory is cleared after reset, the block is busy meanwhile
`timescale 1ns/10ps
`include "sep_consts.svh"

module sep_eeprom_slave
   import sep_pkg::*;
#(
   parameter int P_TWR_CYC = `SEP_TWR_CYC
) (
   // reference clock and reset
   input wire logic i_ref_clk,
   input wire logic i_arst_n,
   // two-wire link
   input wire logic i_scl_clk,
   input wire logic i_sda,
   output logic o_sda_out,
   output logic o_sda_oe,
   // status
   output logic o_busy
);

   localparam int AW = `SEP_ADDR_W;
   localparam int PW = `SEP_PAGE_W;
   localparam int PD = 1 << PW;
   localparam int TW = $clog2(P_TWR_CYC + 1);
   localparam logic [6:0] TDLY = 7'(`SEP_TDLY_CYC);
   localparam logic [AW-1:0] CLR_END = '1;

   // ------------------------------------------------------------
   // link domain: bit capture on the serial clock
   // ------------------------------------------------------------
   logic [7:0] lsh_r;
   logic [7:0] lsh_nxt;

   // sampled at rising clock, when data is stable
   always_comb begin
      lsh_nxt = {lsh_r[6:0], i_sda}; // R5
   end

   always_ff @(posedge i_scl_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         lsh_r <= 8'h00;
      end else begin
         lsh_r <= lsh_nxt;
      end
   end

   // ------------------------------------------------------------
   // reference domain: line synchronisers and conditions
   // ------------------------------------------------------------
   logic [2:0] scl_q_r;
   logic [2:0] scl_q_nxt;
   logic [2:0] sda_q_r;
   logic [2:0] sda_q_nxt;

   // stage 0 feeds stage 1 only; stage 2 is the previous level
   always_comb begin
      scl_q_nxt = {scl_q_r[1:0], i_scl_clk};
      sda_q_nxt = {sda_q_r[1:0], i_sda};
   end

   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         scl_q_r <= 3'h7;
         sda_q_r <= 3'h7;
      end else begin
         scl_q_r <= scl_q_nxt;
         sda_q_r <= sda_q_nxt;
      end
   end

   logic scl_h;
   logic scl_p;
   logic sda_h;
   logic sda_p;
   logic rise;
   logic fall;
   logic start_ev;
   logic stop_ev;
   logic byte_done;
   logic [7:0] byte_in;

   // conditions need clock high on both samples
   assign scl_h = scl_q_r[1];
   assign scl_p = scl_q_r[2];
   assign sda_h = sda_q_r[1];
   assign sda_p = sda_q_r[2];
   assign rise = scl_h & ~scl_p;
   assign fall = ~scl_h & scl_p;
   assign start_ev = scl_h & scl_p & sda_p & ~sda_h; // R2 R3
   assign stop_ev = scl_h & scl_p & ~sda_p & sda_h; // R4 R1
   // link byte is read two cycles after its edge, and it holds
   // until the next rising edge, so it is stable when taken
   assign byte_in = lsh_r;

   // ------------------------------------------------------------
   // transfer sequencer
   // ------------------------------------------------------------
   sep_state_t st_r;
   sep_state_t st_nxt;
   logic [3:0] cnt_r;
   logic [3:0] cnt_nxt;
   logic [AW-1:0] ptr_r;
   logic [AW-1:0] ptr_nxt;
   logic [7:0] tx_r;
   logic [7:0] tx_nxt;
   logic ack_r;
   logic ack_nxt;
   logic pend_r;
   logic pend_nxt;
   logic [6:0] dly_r;
   logic [6:0] dly_nxt;
   logic oe_r;
   logic oe_nxt;
   logic [PD-1:0] vld_r;
   logic [PD-1:0] vld_nxt;
   logic buf_we;
   logic go_prog;
   logic busy_r;
   logic [TW-1:0] tmr_r;
   logic [7:0] mem_q;

   assign byte_done = rise && (cnt_r == `SEP_LAST_BIT);

   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      ptr_nxt = ptr_r;
      tx_nxt = tx_r;
      ack_nxt = ack_r;
      pend_nxt = pend_r;
      dly_nxt = dly_r;
      oe_nxt = oe_r;
      vld_nxt = vld_r;
      buf_we = 1'b0;
      go_prog = 1'b0;
      // nine rising edges per byte, the last one is the ack slot
      if (rise) begin
         cnt_nxt = (cnt_r == `SEP_ACK_BIT) ? 4'h0 : cnt_r + 4'h1; // R6
      end
      if (byte_done) begin
         unique case (st_r)
            sep_idle: begin
               ack_nxt = 1'b0;
            end
            sep_ctrl: begin
               if (byte_in[7:4] == `SEP_CTRL_CODE && byte_in[3:1] == `SEP_CTRL_SEL
                   && !busy_r) begin // R9 R8 R17
                  ack_nxt = 1'b1; // R10
                  st_nxt = byte_in[0] ? sep_rd : sep_adrh; // R18
               end else begin
                  ack_nxt = 1'b0; // R11
                  st_nxt = sep_idle; // R11
               end
            end
            sep_adrh: begin
               ptr_nxt[AW-1:8] = byte_in[AW-9:0]; // R12
               ack_nxt = 1'b1; // R13
               st_nxt = sep_adrl;
            end
            sep_adrl: begin
               ptr_nxt[7:0] = byte_in; // R13
               ack_nxt = 1'b1;
               st_nxt = sep_wr;
            end
            sep_wr: begin
               buf_we = 1'b1; // R15
               vld_nxt[ptr_r[PW-1:0]] = 1'b1;
               ptr_nxt[PW-1:0] = ptr_r[PW-1:0] + 1'b1; // R16
               ack_nxt = 1'b1; // R14
            end
            sep_rd: begin
               ptr_nxt = ptr_r + 1'b1; // R22 R18
               ack_nxt = 1'b0;
            end
         endcase
      end
      // ack slot: in read, either our own ack or the master's answer
      if (rise && cnt_r == `SEP_ACK_BIT && st_r == sep_rd) begin
         if (!ack_r && sda_h) begin
            st_nxt = sep_idle; // R20 R21
         end else begin
            tx_nxt = mem_q; // R20
         end
      end
      // schedule the data line a fixed delay after the falling clock
      if (fall) begin
         dly_nxt = TDLY; // R23
         if (cnt_r == `SEP_ACK_BIT) begin
            pend_nxt = ack_r; // R7
         end else if (st_r == sep_rd) begin
            pend_nxt = ~tx_r[3'h7 - cnt_r[2:0]];
         end else begin
            pend_nxt = 1'b0; // R21
         end
      end else if (dly_r != 7'h00) begin
         dly_nxt = dly_r - 7'h01;
         if (dly_r == 7'h01) begin
            oe_nxt = pend_r; // R1 R23
         end
      end
      // a finished write cycle frees the page buffer
      if (tmr_r == TW'(1)) begin
         vld_nxt = '0;
      end
      // repeated start drops unprogrammed data but keeps the pointer
      if (start_ev) begin
         st_nxt = sep_ctrl; // R3 R10
         cnt_nxt = 4'h0;
         dly_nxt = 7'h00;
         oe_nxt = 1'b0;
         if (!busy_r) begin
            vld_nxt = '0; // R19
         end
      end
      if (stop_ev) begin
         st_nxt = sep_idle; // R4
         cnt_nxt = 4'h0;
         dly_nxt = 7'h00;
         oe_nxt = 1'b0;
         if (st_r == sep_wr && vld_r != '0 && !busy_r) begin
            go_prog = 1'b1; // R14 R15
         end else if (!busy_r) begin
            vld_nxt = '0;
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st_r <= sep_idle;
         cnt_r <= 4'h0;
         ptr_r <= '0;
         tx_r <= 8'h00;
         ack_r <= 1'b0;
         pend_r <= 1'b0;
         dly_r <= 7'h00;
         oe_r <= 1'b0;
         vld_r <= '0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         ptr_r <= ptr_nxt;
         tx_r <= tx_nxt;
         ack_r <= ack_nxt;
         pend_r <= pend_nxt;
         dly_r <= dly_nxt;
         oe_r <= oe_nxt;
         vld_r <= vld_nxt;
      end
   end

   // ------------------------------------------------------------
   // write cycle timer, page commit and power-up clear
   // ------------------------------------------------------------
   logic clr_r;
   logic clr_nxt;
   logic [AW-1:0] clr_idx_r;
   logic [AW-1:0] clr_idx_nxt;
   logic [TW-1:0] tmr_nxt;
   logic [PW:0] prog_r;
   logic [PW:0] prog_nxt;
   logic busy_nxt;
   logic mem_we;
   logic [AW-1:0] mem_addr;
   logic [7:0] mem_din;
   logic [7:0] buf_r [0:PD-1];
   logic [7:0] mem_r [0:(1<<AW)-1];

   // commit copies one buffer entry per cycle at the start of the
   // cycle; the rest of the cycle is pure wait for polling
   always_comb begin
      clr_nxt = clr_r;
      clr_idx_nxt = clr_idx_r;
      tmr_nxt = tmr_r;
      prog_nxt = prog_r;
      mem_we = 1'b0;
      mem_addr = {ptr_r[AW-1:PW], prog_r[PW-1:0]};
      mem_din = buf_r[prog_r[PW-1:0]];
      if (clr_r) begin
         mem_we = 1'b1;
         mem_addr = clr_idx_r;
         mem_din = 8'h00;
         clr_idx_nxt = clr_idx_r + 1'b1;
         if (clr_idx_r == CLR_END) begin
            clr_nxt = 1'b0;
         end
      end else if (go_prog) begin
         tmr_nxt = TW'(P_TWR_CYC); // R14 R15
         prog_nxt = '0;
      end else if (tmr_r != '0) begin
         tmr_nxt = tmr_r - 1'b1; // R17
         if (!prog_r[PW]) begin
            mem_we = vld_r[prog_r[PW-1:0]]; // R15
            prog_nxt = prog_r + 1'b1;
         end
      end
      busy_nxt = clr_nxt || (tmr_nxt != '0);
   end

   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         clr_r <= 1'b1;
         clr_idx_r <= '0;
         tmr_r <= '0;
         prog_r <= {1'b1, {PW{1'b0}}};
         busy_r <= 1'b1;
      end else begin
         clr_r <= clr_nxt;
         clr_idx_r <= clr_idx_nxt;
         tmr_r <= tmr_nxt;
         prog_r <= prog_nxt;
         busy_r <= busy_nxt;
      end
   end

   // page buffer, later bytes overwrite on wrap
   always_ff @(posedge i_ref_clk) begin
      if (buf_we) begin
         buf_r[ptr_r[PW-1:0]] <= byte_in; // R16
      end
   end

   // array storage, no reset; cleared by the sweep instead
   always_ff @(posedge i_ref_clk) begin
      if (mem_we) begin
         mem_r[mem_addr] <= mem_din;
      end
   end

   assign mem_q = mem_r[ptr_r]; // R18

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   logic out_r;

   // open drain: only ever pulls low
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         out_r <= 1'b0;
      end else begin
         out_r <= 1'b0;
      end
   end

   assign o_sda_out = out_r;
   assign o_sda_oe = oe_r;
   assign o_busy = busy_r;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_arst_n);

   sequence s_ctrl_ok;
      st_r == sep_ctrl && byte_done && byte_in[7:4] == `SEP_CTRL_CODE
         && byte_in[3:1] == `SEP_CTRL_SEL;
   endsequence

   sequence s_master_nack;
      st_r == sep_rd && rise && cnt_r == `SEP_ACK_BIT && !ack_r && sda_h;
   endsequence

   busy_no_ack_a: assert property (s_ctrl_ok and busy_r |=> !ack_r && st_r == sep_idle) // R8
      else $error("acknowledge armed while busy");
   ctrl_ack_a: assert property (s_ctrl_ok and !busy_r |=> ack_r && st_r != sep_idle) // R10
      else $error("matching control byte not acknowledged");
   ctrl_miss_a: assert property (st_r == sep_ctrl && byte_done
         && byte_in[7:4] != `SEP_CTRL_CODE |=> st_r == sep_idle && !ack_r) // R11
      else $error("foreign control byte accepted");
   start_seq_a: assert property (start_ev |=> st_r == sep_ctrl && cnt_r == 4'h0) // R3
      else $error("start did not restart the byte");
   stop_idle_a: assert property (stop_ev |=> st_r == sep_idle && !oe_r) // R4
      else $error("stop did not idle the slave");
   oe_hold_a: assert property (fall |=> (oe_r == $past(oe_r)) [*8]) // R23
      else $error("data line moved too soon after clock fall");
   oe_when_a: assert property ($changed(oe_r) && !$past(start_ev) && !$past(stop_ev)
         |-> $past(dly_r) == 7'h01 && !scl_h) // R1
      else $error("data line moved outside the delayed low phase");
   page_step_a: assert property (st_r == sep_wr && byte_done && !start_ev && !stop_ev
         |=> ptr_r[AW-1:PW] == $past(ptr_r[AW-1:PW])
         && ptr_r[PW-1:0] == $past(ptr_r[PW-1:0]) + 1'b1) // R16
      else $error("page pointer did not step within page");
   read_step_a: assert property (st_r == sep_rd && byte_done && !start_ev && !stop_ev
         |=> ptr_r == $past(ptr_r) + 1'b1) // R22
      else $error("read pointer did not step");
   commit_a: assert property (stop_ev && st_r == sep_wr && vld_r != '0 && !busy_r
         |=> busy_r [*8]) // R14
      else $error("stop did not launch the write cycle");
   no_prog_a: assert property (start_ev && st_r == sep_wr && !busy_r
         |=> !busy_r && vld_r == '0) // R19
      else $error("repeated start programmed the page");
   nack_rel_a: assert property (s_master_nack and !start_ev and !stop_ev
         |=> st_r == sep_idle ##1 !fall [*1] ##0 !oe_r) // R21
      else $error("data line kept after master nack");

endmodule

/* File: hw/sep_consts.svh */
// Purpose: shared constants for the two-wire serial memory slave
// Assumes: reference clock at SEP_CLK_MHZ
// Notes: timing counts derive from times held in their own units
//
// What this block does
// [R1] data line changes only while clock low; changes with clock high are conditions
// [R2] bus idle means both lines high; new transfers begin from idle
// [R3] data falling while clock high is START, opening every command
// [R4] data rising while clock high is STOP, closing every operation
// [R5] one clock pulse per bit; data stable through the high phase
// [R6] receiver acknowledges each byte on a ninth master clock pulse
// [R7] acknowledger holds data low through the whole ack clock high phase
// [R8] no acknowledge at all while the internal write cycle runs
// [R9] control byte: code 1010, select bits zero, last bit read/write
// [R10] watch control byte after START; acknowledge a match, then read or write
// [R11] mismatching control byte: stay released, wait for the next START
// [R12] two address bytes follow, msb first; only low twelve bits count
// [R13] acknowledge write control byte, load high then low address, ack each
// [R14] byte write: ack data byte; following STOP launches the internal write
// [R15] page write buffers up to 32 bytes, committed only after STOP
// [R16] low five pointer bits step per data byte, wrapping and overwriting
// [R17] busy device withholds acknowledge to polling; acks when write ends
// [R18] pointer holds last address plus one; current read starts there
// [R19] repeated START after address ends write unprogrammed, keeps the pointer
// [R20] master ack requests next byte; nack plus STOP ends sending
// [R21] after master nack the data line is released high
// [R22] sequential read pointer wraps from 0FFF to 000 over the array
// [R23] sent data changes at least 300 ns after the clock falls
`ifndef SEP_CONSTS_SVH
`define SEP_CONSTS_SVH

`define SEP_CLK_MHZ 200
`define SEP_TDLY_NS 300
`define SEP_TDLY_CYC ((`SEP_TDLY_NS * `SEP_CLK_MHZ + 999) / 1000)
`define SEP_TWR_MS 5
`define SEP_TWR_CYC (`SEP_TWR_MS * 1000 * 1000 * `SEP_CLK_MHZ / 1000)
`define SEP_CTRL_CODE 4'hA
`define SEP_CTRL_SEL 3'h0
`define SEP_ADDR_W 12
`define SEP_PAGE_W 5
`define SEP_LAST_BIT 4'h7
`define SEP_ACK_BIT 4'h8

`endif

/* File: hw/sep_pkg.sv */
// Purpose: types for the two-wire serial memory slave
// Assumes: nothing
// Notes: protocol phases of one transfer
package sep_pkg;
   typedef enum logic [2:0] {
      sep_idle,
      sep_ctrl,
      sep_adrh,
      sep_adrl,
      sep_wr,
      sep_rd
   } sep_state_t;
endpackage

/* File: verification/sep_master_model.sv */
// Purpose: behavioural two-wire bus master facing the serial memory slave
// Assumes: open-drain data wire resolved in the bench, pull-up when released
// Notes: clock stands still between frames; low phase 640 ns, high 320 ns
`timescale 1ns/10ps

module sep_master_model (
   // tick clock and resolved wire
   input wire logic i_link_clk,
   input wire logic i_sda,
   // driven lines
   output logic o_scl_clk,
   output logic o_sda_low
);
   //----------------------------------------
   // bit and frame tasks
   //----------------------------------------
   logic r;

   // idle bus: both lines high
   initial begin
      o_scl_clk = 1'b1;
      o_sda_low = 1'b0;
   end

   // long low phase lets the slave's delayed output settle before the rise
   task automatic clk_bit(input logic b, output logic s);
      @(posedge i_link_clk) o_sda_low <= ~b;
      repeat (3) @(posedge i_link_clk);
      o_scl_clk <= 1'b1;
      repeat (2) @(posedge i_link_clk);
      s = i_sda;
      o_scl_clk <= 1'b0;
   endtask

   // waits out the slave's release before raising data
   task automatic start();
      repeat (3) @(posedge i_link_clk);
      o_sda_low <= 1'b0;
      @(posedge i_link_clk) o_scl_clk <= 1'b1;
      repeat (2) @(posedge i_link_clk);
      o_sda_low <= 1'b1;
      repeat (2) @(posedge i_link_clk);
      o_scl_clk <= 1'b0;
   endtask

   // rel reports whether the wire was free before the master pulled it
   task automatic stop(output logic rel);
      repeat (3) @(posedge i_link_clk);
      rel = i_sda;
      o_sda_low <= 1'b1;
      @(posedge i_link_clk) o_scl_clk <= 1'b1;
      repeat (2) @(posedge i_link_clk);
      o_sda_low <= 1'b0;
      repeat (4) @(posedge i_link_clk);
   endtask

   task automatic wbyte(input logic [7:0] d, output logic ack);
      for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
      clk_bit(1'b1, r);
      ack = ~r;
   endtask

   task automatic rbyte(input logic mack, output logic [7:0] d);
      for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
      clk_bit(~mack, r);
   endtask
endmodule

/* File: verification/tb.sv */
// Purpose: self-checking bench for the two-wire serial memory slave
// Assumes: write cycle shortened through P_TWR_CYC
// Notes: memory model is an int array mirrored from the bus traffic
`timescale 1ns/10ps

module tb;
   //----------------------------------------
   // signals and instances
   //----------------------------------------
   localparam int TWR = 3000;
   logic i_ref_clk, i_arst_n, lck, scl, m_low, sda_w, o_sda_out, o_sda_oe, o_busy;
   logic ack, rel;
   logic [7:0] d;
   logic [7:0] bad [4] = '{8'hB0, 8'hA2, 8'hA8, 8'h21};
   int miscompares = 0;
   int compares = 0;
   int cycles = 0;
   int seed = 32'h3469;
   int ptr = 0;
   int mem [4096];

   // wire low when either party pulls it
   assign sda_w = ~((o_sda_oe && o_sda_out === 1'b0) || m_low);

   sep_eeprom_slave #(.P_TWR_CYC(TWR)) sep_eeprom_slave_i (.i_ref_clk(i_ref_clk),
      .i_arst_n(i_arst_n), .i_scl_clk(scl), .i_sda(sda_w), .o_sda_out(o_sda_out),
      .o_sda_oe(o_sda_oe), .o_busy(o_busy));
   sep_master_model sep_master_model_i (.i_link_clk(lck), .i_sda(sda_w),
      .o_scl_clk(scl), .o_sda_low(m_low));

   // clocks, link tick offset so phases never line up
   initial begin
      i_ref_clk = 1'b0;
      forever #2.5 i_ref_clk = ~i_ref_clk;
   end
   initial begin
      lck = 1'b0;
      #37;
      forever #80 lck = ~lck;
   end

   // hang guard
   always @(posedge i_ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 97000) begin
         miscompares++;
         stop_test();
      end
   end

   //----------------------------------------
   // helpers
   //----------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic stop_test();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic ctrl(input logic [7:0] c, input logic exp);
      sep_master_model_i.start();
      sep_master_model_i.wbyte(c, ack);
      chk(ack, exp);
   endtask

   // control byte plus both address bytes, pointer follows
   task automatic addr_phase(input int adr);
      ctrl(8'hA0, 1'b1);
      sep_master_model_i.wbyte(8'(adr >> 8), ack);
      chk(ack, 1'b1);
      sep_master_model_i.wbyte(8'(adr), ack);
      chk(ack, 1'b1);
      ptr = adr;
   endtask

   // first poll lands inside the write cycle, later ones end it
   task automatic poll();
      int n;
      n = 0;
      ack = 1'b0;
      while (ack !== 1'b1 && n < 20) begin
         // each poll is judged on its own answer, not on the previous one
         sep_master_model_i.start();
         sep_master_model_i.wbyte(8'hA0, ack);
         sep_master_model_i.stop(rel);
         if (n == 0) chk(ack, 1'b0);
         n++;
      end
      chk(ack, 1'b1);
   endtask

   task automatic do_write(input int adr, input int n);
      int a;
      addr_phase(adr);
      for (int k = 0; k < n; k++) begin
         d = 8'($random(seed));
         a = (adr & 32'hFE0) | ((adr + k) & 32'h1F);
         mem[a] = d;
         sep_master_model_i.wbyte(d, ack);
         chk(ack, 1'b1);
      end
      ptr = (adr & 32'hFE0) | ((adr + n) & 32'h1F);
      sep_master_model_i.stop(rel);
      poll();
   endtask

   // negative address means a current address read
   task automatic do_read(input int adr, input int n);
      if (adr >= 0) addr_phase(adr);
      ctrl(8'hA1, 1'b1);
      for (int k = 0; k < n; k++) begin
         sep_master_model_i.rbyte(k < n - 1, d);
         chk(d, 8'(mem[ptr]));
         ptr = (ptr + 1) & 32'hFFF;
      end
      sep_master_model_i.stop(rel);
      chk(rel, 1'b1);
   endtask

   //----------------------------------------
   // main sequence
   //----------------------------------------
   initial begin
      i_arst_n = 1'b0;
      repeat (10) @(posedge i_ref_clk);
      i_arst_n <= 1'b1;
      ctrl(8'hA0, 1'b0);
      sep_master_model_i.stop(rel);
      for (int w = 0; w < 6000 && o_busy !== 1'b0; w++) @(posedge i_ref_clk);
      chk(o_busy, 1'b0);
      $display("test busy poll done");
      foreach (bad[i]) begin
         ctrl(bad[i], 1'b0);
         sep_master_model_i.stop(rel);
      end
      $display("test bad control done");
      do_write(32'h01D, 4);
      do_read(32'h01D, 4);
      $display("test page write done");
      do_write(32'h100, 2);
      do_read(32'h100, 1);
      do_read(-1, 1);
      $display("test current read done");
      do_read(32'hFFF, 2);
      $display("test wrap read done");
      stop_test();
   end
endmodule
